//--- core/scbd_consts.vh
`ifndef SCBD_CONSTS_VH
`define SCBD_CONSTS_VH
// Command byte layout
`define SCBD_CMD_BIT       7
`define SCBD_TYPE_HI       6
`define SCBD_TYPE_LO       5
`define SCBD_ADDR_HI       4
`define SCBD_ADDR_LO       0
// Transfer types
`define SCBD_TYPE_REPEAT   2'h0
`define SCBD_TYPE_AUTOINC  2'h1
`define SCBD_TYPE_RSVD     2'h2
`define SCBD_TYPE_SPECIAL  2'h3
// Special function codes
`define SCBD_SF_NOP        5'h00
`define SCBD_SF_CLR_PROX   5'h05
`define SCBD_SF_CLR_CLEAR  5'h06
`define SCBD_SF_CLR_BOTH   5'h07
// Bus address and reset values
`define SCBD_SLAVE_ADDR    7'h39
`define SCBD_PTR_RESET     5'h00
`define SCBD_TYPE_RESET    2'h0
`endif

//--- core/scbd_decoder.v
// Notes on behaviour
// - Captured address targets later data transfers
// - Bits 6:5 select transfer type
// - Type 00 keeps pointer fixed
// - Type 01 advances pointer per byte
// - Bits 4:0 are address or function code
// - Function code 00000 does nothing
// - Codes 5,6,7 clear prox, clear, both
// - Interrupt clears are one-shot pulses
// - Read without command uses stored address
// - Interrupt stays until matching clear
// - Respond only to slave address 0x39
`timescale 1ns/1ns
`include "scbd_consts.vh"
module scbd_decoder (
  input  wire       clk_sys,
  input  wire       resetn,
  input  wire       start_seen,
  input  wire       addr_valid,
  input  wire [6:0] addr_byte,
  input  wire       addr_rw,
  input  wire       byte_valid,
  input  wire [7:0] byte_data,
  input  wire       read_ack,
  input  wire       prox_event,
  input  wire       clear_event,
  output reg        selected,
  output reg  [4:0] reg_ptr,
  output reg  [1:0] xfer_type,
  output reg        wr_strobe,
  output reg  [4:0] wr_addr,
  output reg  [7:0] wr_data,
  output reg        sf_clr_prox,
  output reg        sf_clr_clear,
  output reg        prox_int,
  output reg        clear_int
);

  // Transaction state and next values
  reg        first_byte;
  reg  [4:0] next_ptr;
  reg        next_selected;
  reg        next_first_byte;
  reg  [4:0] next_reg_ptr;
  reg  [1:0] next_xfer_type;
  reg        next_wr_strobe;
  reg  [4:0] next_wr_addr;
  reg  [7:0] next_wr_data;
  reg        next_sf_clr_prox;
  reg        next_sf_clr_clear;
  reg        next_prox_int;
  reg        next_clear_int;

  // Pointer step after a data byte, held in repeat mode
  function [4:0] step_ptr;
    input [4:0] p;
    input [1:0] t;
    begin
      if (t == `SCBD_TYPE_AUTOINC) begin
        step_ptr = p + 5'h01;
      end else begin
        step_ptr = p;
      end
    end
  endfunction

  // Own bus address compare
  function addr_match;
    input [6:0] a;
    begin
      addr_match = (a == `SCBD_SLAVE_ADDR);
    end
  endfunction

  // Function code decode: bit 0 proximity clear, bit 1 clear-channel clear
  function [1:0] sf_decode;
    input [4:0] code;
    begin
      case (code)
        `SCBD_SF_CLR_PROX: begin
          sf_decode = 2'h1;
        end
        `SCBD_SF_CLR_CLEAR: begin
          sf_decode = 2'h2;
        end
        `SCBD_SF_CLR_BOTH: begin
          sf_decode = 2'h3;
        end
        default: begin
          sf_decode = 2'h0; // no action, reserved codes ignored
        end
      endcase
    end
  endfunction

  // Sticky flag update; a new event beats a clear in the same cycle
  function sticky_next;
    input cur;
    input set;
    input clr;
    begin
      if (set) begin
        sticky_next = 1'b1;
      end else if (clr) begin
        sticky_next = 1'b0;
      end else begin
        sticky_next = cur;
      end
    end
  endfunction

  // Command byte fields
  wire       is_cmd   = byte_data[`SCBD_CMD_BIT];
  wire [1:0] cmd_type = byte_data[`SCBD_TYPE_HI:`SCBD_TYPE_LO];
  wire [4:0] cmd_fld  = byte_data[`SCBD_ADDR_HI:`SCBD_ADDR_LO];

  // Accepted bytes: only while selected; command only as first byte
  wire       data_take = byte_valid && selected;
  wire       cmd_take  = data_take && first_byte && is_cmd;
  wire [1:0] sf_hit    = sf_decode(cmd_fld);

  // Pointer after one data or read byte
  always @* begin
    next_ptr = step_ptr(reg_ptr, xfer_type);
  end

  // Selection and first-byte tracking; start drops the transaction
  always @* begin
    next_selected   = selected;
    next_first_byte = first_byte;
    if (start_seen) begin
      next_selected   = 1'b0;
      next_first_byte = 1'b0;
    end else if (addr_valid) begin
      next_selected   = addr_match(addr_byte);
      next_first_byte = addr_match(addr_byte) && !addr_rw;
    end else if (data_take) begin
      next_first_byte = 1'b0;
    end
  end

  // Command capture, pointer stepping and write strobes
  always @* begin
    next_reg_ptr      = reg_ptr;
    next_xfer_type    = xfer_type;
    next_wr_strobe    = 1'b0;
    next_wr_addr      = wr_addr;
    next_wr_data      = wr_data;
    next_sf_clr_prox  = 1'b0;
    next_sf_clr_clear = 1'b0;
    if (cmd_take) begin
      if (cmd_type == `SCBD_TYPE_SPECIAL) begin
        next_sf_clr_prox  = sf_hit[0];
        next_sf_clr_clear = sf_hit[1];
      end else if (cmd_type != `SCBD_TYPE_RSVD) begin
        next_reg_ptr   = cmd_fld;
        next_xfer_type = cmd_type;
      end
    end else if (data_take) begin
      // Data write, also first byte without bit 7 set
      next_wr_strobe = 1'b1;
      next_wr_addr   = reg_ptr;
      next_wr_data   = byte_data;
      next_reg_ptr   = next_ptr;
    end else if (read_ack && selected) begin
      next_reg_ptr = next_ptr;
    end
  end

  // Interrupt levels
  always @* begin
    next_prox_int  = sticky_next(prox_int, prox_event, sf_clr_prox);
    next_clear_int = sticky_next(clear_int, clear_event, sf_clr_clear);
  end

  // Selection register
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      selected <= 1'b0;
    end else begin
      selected <= next_selected;
    end
  end

  // First-byte register
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      first_byte <= 1'b0;
    end else begin
      first_byte <= next_first_byte;
    end
  end

  // Pointer and transfer type
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_ptr   <= `SCBD_PTR_RESET;
      xfer_type <= `SCBD_TYPE_RESET;
    end else begin
      reg_ptr   <= next_reg_ptr;
      xfer_type <= next_xfer_type;
    end
  end

  // Write port towards the register file
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wr_strobe <= 1'b0;
      wr_addr   <= 5'h00;
      wr_data   <= 8'h00;
    end else begin
      wr_strobe <= next_wr_strobe;
      wr_addr   <= next_wr_addr;
      wr_data   <= next_wr_data;
    end
  end

  // One-shot clear pulses
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sf_clr_prox  <= 1'b0;
      sf_clr_clear <= 1'b0;
    end else begin
      sf_clr_prox  <= next_sf_clr_prox;
      sf_clr_clear <= next_sf_clr_clear;
    end
  end

  // Sticky interrupt flags
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prox_int  <= 1'b0;
      clear_int <= 1'b0;
    end else begin
      prox_int  <= next_prox_int;
      clear_int <= next_clear_int;
    end
  end

endmodule // scbd_decoder

//--- tb/scbd_sva.sv
`timescale 1ns/1ns
module scbd_sva(input wire clk_sys,resetn,start_seen,addr_valid,byte_valid,selected,wr_strobe,prox_event,
  sf_clr_prox,sf_clr_clear,prox_int,clear_int,clear_event,input wire [6:0] addr_byte,input wire [7:0] byte_data,
  input wire [4:0] reg_ptr,wr_addr,input wire [1:0] xfer_type);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Selection, writes, pointer steps, clears
  AST_SEL: assert property (addr_valid&&addr_byte==7'h39&&!start_seen |=> selected) else $error("sel");
  AST_WR: assert property (wr_strobe |-> $past(byte_valid&&selected)) else $error("wr");
  AST_REP: assert property (wr_strobe&&xfer_type==2'h0 |-> reg_ptr==wr_addr) else $error("rep");
  AST_INC: assert property (wr_strobe&&xfer_type==2'h1 |-> reg_ptr==wr_addr+5'h01) else $error("inc");
  AST_PLS: assert property (sf_clr_prox |=> !sf_clr_prox) else $error("pls");
  AST_NOP: assert property (byte_valid&&byte_data==8'hE0 |=> !sf_clr_prox&&!sf_clr_clear) else $error("nop");
  AST_CLR: assert property (sf_clr_prox&&!prox_event |=> !prox_int) else $error("clr");
  AST_STK: assert property (prox_int&&!sf_clr_prox |=> prox_int) else $error("stk");
  AST_CCLR: assert property (sf_clr_clear&&!clear_event |=> !clear_int) else $error("cclr");
  AST_CSTK: assert property (clear_int&&!sf_clr_clear |=> clear_int) else $error("cstk");
  cover property (sf_clr_prox&&sf_clr_clear);
  cover property (wr_strobe&&xfer_type==2'h1);
  cover property (wr_strobe&&xfer_type==2'h0);
endmodule // scbd_sva

//--- tb/scbd_host.sv
`timescale 1ns/1ns
module scbd_host(input wire clk_sys,output reg start_seen,addr_valid,addr_rw,byte_valid,read_ack,prox_event,
  clear_event,output reg [6:0] addr_byte,output reg [7:0] byte_data);
  initial {start_seen,addr_valid,addr_rw,byte_valid,read_ack,prox_event,clear_event,addr_byte,byte_data}=0;
  // One-cycle strobe; released data lines show the inverse
  task op(input [5:0] s,input [7:0] d);
    begin
      @(negedge clk_sys) {clear_event,prox_event,read_ack,byte_valid,addr_valid,start_seen}=s;
      {addr_byte,addr_rw}=d;
      byte_data=d;
      @(negedge clk_sys) {clear_event,prox_event,read_ack,byte_valid,addr_valid,start_seen}=6'h00;
      {addr_byte,addr_rw}=~d;
      byte_data=~d;
    end
  endtask
endmodule // scbd_host

//--- tb/sensor_command_byte_decoder_tb.sv
`timescale 1ns/1ns
module sensor_command_byte_decoder_tb;
  reg clk_sys=0,resetn=0;
  integer miscompares=0,samples_checked=0;
  wire [7:0] byte_data,wr_data;
  wire [6:0] addr_byte;
  wire [4:0] reg_ptr,wr_addr;
  wire [1:0] xfer_type;
  wire start_seen,addr_valid,addr_rw,byte_valid,read_ack,prox_event,clear_event,selected,wr_strobe,
    sf_clr_prox,sf_clr_clear,prox_int,clear_int;
  scbd_decoder dut(.*);
  scbd_host host(.*);
  always #20 clk_sys=~clk_sys;
  task chk(input [7:0] g,e);
    begin
      samples_checked=samples_checked+1;
      if (g!==e) begin
        miscompares=miscompares+1;
        $display("ERROR %0t got %h exp %h",$time,g,e);
      end
    end
  endtask
  task results;
    begin
      $display("checked %0d miscompares %0d",samples_checked,miscompares);
      if (miscompares==0&&samples_checked>0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  // Start, write address, command byte with bit 7 set, reserved type included
  task cmd(input [6:0] a,input [7:0] c);
    begin
      host.op(6'h01,8'h00);
      host.op(6'h02,{a,1'b0});
      host.op(6'h04,c);
    end
  endtask
  // Interrupt levels once the clear has landed
  task ints(input [1:0] e);
    begin
      @(negedge clk_sys);
      chk({prox_int,clear_int},e);
    end
  endtask
  // Watchdog
  initial begin
    #20000 miscompares=miscompares+1;
    results;
  end
  // Test sequence
  initial begin
    repeat (6) @(negedge clk_sys);
    resetn=1;
    cmd(7'h39,8'hA3); chk(selected,1); chk(xfer_type,1); chk(reg_ptr,3);
    host.op(6'h04,8'h55); chk(wr_addr,3); chk(wr_data,8'h55); chk(reg_ptr,4);
    chk(wr_strobe,1);
    host.op(6'h08,8'h00); chk(reg_ptr,5);
    cmd(7'h39,8'h82); host.op(6'h04,8'h11); host.op(6'h04,8'h22); chk(wr_data,8'h22); chk(reg_ptr,2);
    cmd(7'h3A,8'h85); cmd(7'h39,8'hC4); chk(reg_ptr,2);
    $display("pointer tests done");
    host.op(6'h30,8'h00); cmd(7'h39,8'hE0); ints(2'h3);
    cmd(7'h39,8'hE5); chk({sf_clr_prox,sf_clr_clear},2'h2); ints(2'h1);
    cmd(7'h39,8'hE6); chk({sf_clr_prox,sf_clr_clear},2'h1); ints(2'h0);
    host.op(6'h30,8'h00); cmd(7'h39,8'hE7); chk({sf_clr_prox,sf_clr_clear},2'h3); ints(2'h0);
    $display("interrupt tests done");
    results;
  end
endmodule // sensor_command_byte_decoder_tb
bind scbd_decoder scbd_sva sva(.*);
